/* include/emb_params.svh */
// Purpose: Constants of the energy metering accumulator.
// Assumes: Wishbone classic slave, 32-bit data, byte addresses.
// Notes: Totals are 64 bit, in primary energy units.
//
// Behaviour
// - An input-selection setting picks own measurement or external pulses.
// - Measurement mode adds new P and Q values every process cycle.
// - Four totals by direction; each sample goes only to its sign's total.
// - Intervals start on clock boundaries, multiples of interval from midnight.
// - At each interval end the four totals are reported upstream.
// - Displayed totals follow accumulation continuously.
// - Impulse mode accumulates the four totals from external meter pulses.
// - Each active or reactive pulse adds its own scale setting.
// - Cumulation off: totals clear right after each report.
// - Cumulation on: totals keep growing across reports.
// - Nominal primary power is rated voltage times rated current.
// - Totals saturate at a variant-dependent factor times nominal power; the code applies no ceiling while that product is zero.
// - Reset input and device restart clear the totals.
// - Totals are primary quantities, scaled by the transformer ratio.
// - Unit prefix kilo or mega is fixed by configuration and shared.
// - Interval setting: off, 5, 10, 15, 30, 60 minutes; default 30.
// - Pulse scales range 1 to 10000, step one, default 100.
// - Reset input acts only while cumulation is on.
// - Pulse inputs are ignored unless impulse mode is selected.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
`define EMB_A_CTRL 6'h00
`define EMB_A_ASCALE 6'h01
`define EMB_A_RSCALE 6'h02
`define EMB_A_RATU 6'h03
`define EMB_A_RATI 6'h04
`define EMB_A_RATIO 6'h05
`define EMB_A_NOM 6'h06
`define EMB_A_MAXLO 6'h07
`define EMB_A_MAXHI 6'h08
`define EMB_A_STAT 6'h09
`define EMB_A_TOT 6'h10
`define EMB_A_REP 6'h18
`define EMB_CTRL_RST 32'h0000_0010
`define EMB_F_SEL 0
`define EMB_F_CUM 1
`define EMB_F_IVL_LO 2
`define EMB_F_IVL_HI 4
`define EMB_F_MEGA 8
`define EMB_F_VAR_LO 9
`define EMB_F_VAR_HI 10
`define EMB_SCALE_MIN 14'h0001
`define EMB_SCALE_MAX 14'h2710
`define EMB_SCALE_RST 14'h0064
`define EMB_RATIO_RST 16'h0001
`define EMB_FAC_V0 26'h031_BCD2
`define EMB_FAC_V1 26'h3E2_C077
`define EMB_FAC_V2 26'h07C_580E
`define EMB_MIN_5 6'h05
`define EMB_MIN_10 6'h0A
`define EMB_MIN_15 6'h0F
`define EMB_MIN_30 6'h1E
`define EMB_MIN_60 6'h3C
`endif

/* include/emb_pkg.sv */
// Purpose: Types of the energy metering accumulator.
// Assumes: Nothing beyond the constants header.
// Notes: Interval codes follow the setting order.
package emb_pkg;
  typedef enum logic [2:0]
  {
    EMB_IVL_OFF,
    EMB_IVL_5,
    EMB_IVL_10,
    EMB_IVL_15,
    EMB_IVL_30,
    EMB_IVL_60
  } emb_ivl_t;
  typedef enum logic {EMB_SEL_MEAS, EMB_SEL_IMP} emb_sel_t;
  typedef logic [63:0] emb_tot_t;
endpackage

/* include/emb_tick_if.sv */
// Purpose: Carries clock-of-day and interval boundary between modules.
// Assumes: One clock domain.
// Notes: boundary is a one-cycle pulse.
interface emb_tick_if;
  import emb_pkg::*;
  emb_ivl_t ivl;
  logic [5:0] minute;
  logic [5:0] second;
  logic sec_tick;
  logic boundary;
  modport timer (input ivl, input minute, input second, input sec_tick,
    output boundary);
  modport core (output ivl, output minute, output second,
    output sec_tick, input boundary);
endinterface

/* rtl/emb_interval_timer.sv */
// Purpose: Flags the start of each accumulation interval.
// Assumes: sec_tick pulses once per second of the clock of day.
// Notes: Hours are multiples of every interval, so minute alone aligns.
`include "emb_params.svh"
module emb_interval_timer
  import emb_pkg::*;
(
  input wire logic clk_i,  // System clock
  input wire logic rst_i,  // Synchronous reset
  emb_tick_if.timer tk     // Clock of day in, boundary out
);
  import emb_pkg::*;
  logic bnd_d;
  logic bnd_q;

  // Interval length in minutes, zero when metering intervals are off
  function automatic logic [5:0] ivl_minutes(input emb_ivl_t v);
    unique case (v)
      EMB_IVL_5: ivl_minutes = `EMB_MIN_5;
      EMB_IVL_10: ivl_minutes = `EMB_MIN_10;
      EMB_IVL_15: ivl_minutes = `EMB_MIN_15;
      EMB_IVL_30: ivl_minutes = `EMB_MIN_30;
      EMB_IVL_60: ivl_minutes = `EMB_MIN_60;
      default: ivl_minutes = 6'h00;
    endcase
  endfunction

  // Trigger at second zero of a minute that is a multiple of the interval
  always_comb
  begin
    logic [5:0] m;
    m = ivl_minutes(tk.ivl);
    bnd_d = 1'b0;
    if (tk.sec_tick && tk.second == 6'h00 && m != 6'h00)
      bnd_d = ((tk.minute % m) == 6'h00);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bnd_q <= 1'b0;
    else
      bnd_q <= bnd_d;
  end

  assign tk.boundary = bnd_q;
endmodule

/* rtl/emb_meter.sv */
// Purpose: Energy metering accumulator with Wishbone register access.
// Assumes: Samples and pulses are synchronous to clk_i.
// Notes: Totals saturate at the computed ceiling unless it is zero; reads of a 64-bit
//        total are two accesses and are not atomic.
`include "emb_params.svh"
module emb_meter
  import emb_pkg::*;
(
  input wire logic clk_i,                 // 200 MHz clock
  input wire logic rst_i,                 // Synchronous reset, restart
  input wire logic wb_cyc_i,              // Bus cycle
  input wire logic wb_stb_i,              // Bus strobe
  input wire logic wb_we_i,               // Write enable
  input wire logic [7:0] wb_adr_i,        // Byte address
  input wire logic [31:0] wb_dat_i,       // Write data
  input wire logic [3:0] wb_sel_i,        // Byte enables
  output logic [31:0] wb_dat_o,           // Read data
  output logic wb_ack_o,                  // Acknowledge
  input wire logic signed [31:0] p_sample_i, // Secondary active power
  input wire logic signed [31:0] q_sample_i, // Secondary reactive power
  input wire logic sample_valid_i,        // Process cycle strobe
  input wire logic active_demand_pulse_in_i,   // Meter pulse
  input wire logic active_supply_pulse_in_i,   // Meter pulse
  input wire logic reactive_demand_pulse_in_i, // Meter pulse
  input wire logic reactive_supply_pulse_in_i, // Meter pulse
  input wire logic meter_reset_i,         // Total reset request
  input wire logic [5:0] rtc_minute_i,    // Minute of hour
  input wire logic [5:0] rtc_second_i,    // Second of minute
  input wire logic rtc_sec_tick_i,        // One pulse per second
  output emb_tot_t active_demand_total_o,    // Live total
  output emb_tot_t active_supply_total_o,    // Live total
  output emb_tot_t reactive_demand_total_o,  // Live total
  output emb_tot_t reactive_supply_total_o,  // Live total
  output emb_tot_t report_tot_o [4],      // Snapshot at interval end
  output logic report_valid_o,            // Report pulse
  output logic unit_mega_o                // Prefix, shared with line meas.
);
  import emb_pkg::*;

  emb_tick_if tk ();

  emb_interval_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk)
  );

  // Configuration registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [13:0] ascale_q, ascale_d;
  logic [13:0] rscale_q, rscale_d;
  logic [15:0] ratu_q, ratu_d;
  logic [15:0] rati_q, rati_d;
  logic [15:0] ratio_q, ratio_d;
  logic [31:0] nom_q, nom_d;
  logic [63:0] max_q, max_d;
  logic [15:0] nrep_q, nrep_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // Accumulation state
  emb_tot_t tot_q [4];
  emb_tot_t tot_d [4];
  emb_tot_t rep_q [4];
  emb_tot_t rep_d [4];
  logic rv_q, rv_d;
  logic [3:0] pin_q;
  logic [3:0] pin_now;
  logic [3:0] pulse_rise;
  emb_tot_t add [4];
  logic wr_en;
  logic [5:0] widx;
  emb_sel_t sel_mode;
  logic cum_mode;

  assign sel_mode = emb_sel_t'(ctrl_q[`EMB_F_SEL]);
  assign cum_mode = ctrl_q[`EMB_F_CUM];
  assign tk.ivl = emb_ivl_t'(ctrl_q[`EMB_F_IVL_HI:`EMB_F_IVL_LO]);
  assign tk.minute = rtc_minute_i;
  assign tk.second = rtc_second_i;
  assign tk.sec_tick = rtc_sec_tick_i;
  assign unit_mega_o = ctrl_q[`EMB_F_MEGA];

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    lane_merge = r;
  endfunction

  // Keeps a pulse scale inside its legal range of one to ten thousand
  function automatic logic [13:0] clamp_scale(input logic [31:0] v);
    if (v < 32'(`EMB_SCALE_MIN))
      clamp_scale = `EMB_SCALE_MIN;
    else if (v > 32'(`EMB_SCALE_MAX))
      clamp_scale = `EMB_SCALE_MAX;
    else
      clamp_scale = v[13:0];
  endfunction

  // Ceiling factor per fitted current-input variant
  function automatic logic [25:0] ceil_factor(input logic [1:0] v);
    unique case (v)
      2'h1: ceil_factor = `EMB_FAC_V1;
      2'h2: ceil_factor = `EMB_FAC_V2;
      default: ceil_factor = `EMB_FAC_V0;
    endcase
  endfunction

  // Read mux; unmapped addresses answer zero
  function automatic logic [31:0] rd_mux(input logic [5:0] a);
    logic [2:0] k;
    k = a[2:0];
    rd_mux = 32'h0000_0000;
    if (a[5:3] == `EMB_A_TOT >> 3)
      rd_mux = k[0] ? tot_q[k[2:1]][63:32] : tot_q[k[2:1]][31:0];
    else if (a[5:3] == `EMB_A_REP >> 3)
      rd_mux = k[0] ? rep_q[k[2:1]][63:32] : rep_q[k[2:1]][31:0];
    else
      unique case (a)
        `EMB_A_CTRL: rd_mux = ctrl_q;
        `EMB_A_ASCALE: rd_mux = {18'h0, ascale_q};
        `EMB_A_RSCALE: rd_mux = {18'h0, rscale_q};
        `EMB_A_RATU: rd_mux = {16'h0, ratu_q};
        `EMB_A_RATI: rd_mux = {16'h0, rati_q};
        `EMB_A_RATIO: rd_mux = {16'h0, ratio_q};
        `EMB_A_NOM: rd_mux = nom_q;
        `EMB_A_MAXLO: rd_mux = max_q[31:0];
        `EMB_A_MAXHI: rd_mux = max_q[63:32];
        `EMB_A_STAT: rd_mux = {16'h0, nrep_q};
        default: rd_mux = 32'h0000_0000;
      endcase
  endfunction

  assign widx = wb_adr_i[7:2];
  // The write commits on the same edge that raises ack
  assign wr_en = ack_d & wb_we_i;

  // Bus slave and configuration next state
  always_comb
  begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = ack_d ? rd_mux(widx) : 32'h0000_0000;
    ctrl_d = ctrl_q;
    ascale_d = ascale_q;
    rscale_d = rscale_q;
    ratu_d = ratu_q;
    rati_d = rati_q;
    ratio_d = ratio_q;
    if (wr_en)
      unique case (widx)
        `EMB_A_CTRL: ctrl_d = lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
        `EMB_A_ASCALE: ascale_d = clamp_scale(
          lane_merge({18'h0, ascale_q}, wb_dat_i, wb_sel_i));
        `EMB_A_RSCALE: rscale_d = clamp_scale(
          lane_merge({18'h0, rscale_q}, wb_dat_i, wb_sel_i));
        `EMB_A_RATU: ratu_d = wb_dat_i[15:0];
        `EMB_A_RATI: rati_d = wb_dat_i[15:0];
        `EMB_A_RATIO: ratio_d = wb_dat_i[15:0];
        default: ;
      endcase
    // Product registered so the ceiling multiply stays off the add path
    nom_d = 32'(ratu_q) * 32'(rati_q);
    max_d = 64'(ceil_factor(ctrl_q[`EMB_F_VAR_HI:`EMB_F_VAR_LO])) *
      64'(nom_q);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `EMB_CTRL_RST;
      ascale_q <= `EMB_SCALE_RST;
      rscale_q <= `EMB_SCALE_RST;
      ratu_q <= 16'h0000;
      rati_q <= 16'h0000;
      ratio_q <= `EMB_RATIO_RST;
      nom_q <= 32'h0000_0000;
      max_q <= 64'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ascale_q <= ascale_d;
      rscale_q <= rscale_d;
      ratu_q <= ratu_d;
      rati_q <= rati_d;
      ratio_q <= ratio_d;
      nom_q <= nom_d;
      max_q <= max_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Pulse edge detect; inputs are already in the clock domain
  assign pin_now = {reactive_supply_pulse_in_i, reactive_demand_pulse_in_i,
    active_supply_pulse_in_i, active_demand_pulse_in_i};
  assign pulse_rise = pin_now & ~pin_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_q <= 4'h0;
    else
      pin_q <= pin_now;
  end

  // Per-total increment from the selected source
  always_comb
  begin
    logic [31:0] pmag;
    logic [31:0] qmag;
    emb_tot_t pscaled;
    emb_tot_t qscaled;
    pmag = p_sample_i[31] ? 32'(-p_sample_i) : p_sample_i;
    qmag = q_sample_i[31] ? 32'(-q_sample_i) : q_sample_i;
    pscaled = 64'(pmag) * 64'(ratio_q);
    qscaled = 64'(qmag) * 64'(ratio_q);
    for (int i = 0; i < 4; i++)
      add[i] = 64'h0;
    if (sel_mode == EMB_SEL_MEAS)
    begin
      if (sample_valid_i)
      begin
        // Zero samples go to neither direction
        if (p_sample_i > 0)
          add[0] = pscaled;
        else if (p_sample_i < 0)
          add[1] = pscaled;
        if (q_sample_i > 0)
          add[2] = qscaled;
        else if (q_sample_i < 0)
          add[3] = qscaled;
      end
    end
    else
    begin
      // Pulses only count in impulse mode
      add[0] = pulse_rise[0] ? 64'(ascale_q) : 64'h0;
      add[1] = pulse_rise[1] ? 64'(ascale_q) : 64'h0;
      add[2] = pulse_rise[2] ? 64'(rscale_q) : 64'h0;
      add[3] = pulse_rise[3] ? 64'(rscale_q) : 64'h0;
    end
  end

  // Report strobe and counter; snapshot holds the pre-clear totals
  always_comb
  begin
    rv_d = tk.boundary;
    nrep_d = tk.boundary ? nrep_q + 16'h0001 : nrep_q;
  end

  // Totals: boundary clear, reset priority, saturating add
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_tot
      always_comb
      begin
        emb_tot_t base;
        logic [64:0] sum;
        // A sample on the clear cycle opens the new interval
        base = (tk.boundary && !cum_mode) ? 64'h0 : tot_q[g];
        sum = {1'b0, base} + {1'b0, add[g]};
        rep_d[g] = tk.boundary ? tot_q[g] : rep_q[g];
        if (sum[64] || (max_q != 64'h0 && sum[63:0] > max_q))
          tot_d[g] = max_q;
        else
          tot_d[g] = sum[63:0];
        if (meter_reset_i && cum_mode)
          tot_d[g] = 64'h0;
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          tot_q[g] <= 64'h0;
          rep_q[g] <= 64'h0;
        end
        else
        begin
          tot_q[g] <= tot_d[g];
          rep_q[g] <= rep_d[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rv_q <= 1'b0;
      nrep_q <= 16'h0000;
    end
    else
    begin
      rv_q <= rv_d;
      nrep_q <= nrep_d;
    end
  end

  // Live outputs straight from the total flops
  assign active_demand_total_o = tot_q[0];
  assign active_supply_total_o = tot_q[1];
  assign reactive_demand_total_o = tot_q[2];
  assign reactive_supply_total_o = tot_q[3];
  assign report_tot_o = rep_q;
  assign report_valid_o = rv_q;
endmodule

/* tb/emb_meter_bench.sv */
// Purpose: Self-checking bench for the energy metering block.
// Assumes: Bus tasks keep classic Wishbone single cycles.
// Notes: Expected totals are worked out from the sample values.
`include "emb_params.svh"
module emb_meter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import emb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [3:0] wb_sel_i = 4'h0, go = 4'h0;
  logic wb_ack_o, report_valid_o, unit_mega_o, rtc_sec_tick_i;
  logic signed [31:0] p_sample_i = 32'sh0, q_sample_i = 32'sh0;
  logic sample_valid_i = 1'b0, meter_reset_i = 1'b0, tick_go = 1'b0;
  logic [5:0] min_set = 6'h00, rtc_minute_i, rtc_second_i;
  wire logic [3:0] pin;
  wire active_demand_pulse_in_i = pin[0];
  wire active_supply_pulse_in_i = pin[1];
  wire reactive_demand_pulse_in_i = pin[2];
  wire reactive_supply_pulse_in_i = pin[3];
  emb_tot_t active_demand_total_o, active_supply_total_o;
  emb_tot_t reactive_demand_total_o, reactive_supply_total_o;
  emb_tot_t report_tot_o [4];
  emb_tot_t fac [3] = '{64'h31_BCD2, 64'h3E2_C077, 64'h7C_580E};
  int err_total = 0, num_checks = 0, ncyc = 0;
  emb_meter dut_u (.*);
  emb_meter_partner far_u (.clk_i, .rst_i, .go_i(go), .tick_go_i(tick_go),
    .min_i(min_set), .pulse_o(pin), .min_o(rtc_minute_i),
    .sec_o(rtc_second_i), .tick_o(rtc_sec_tick_i));
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge clk_i)
  begin
    ncyc++;
    if (ncyc == 20000)
    begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      test_done;
    end
  end
  task automatic note(input bit ok, input string m);
    num_checks++;
    if (!ok)
    begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; the request holds until ack is sampled
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk_bus(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    note(rdat === e, "read data");
  endtask
  task automatic chk_tot(input emb_tot_t g, input emb_tot_t e);
    note(g === e, "total");
  endtask
  task automatic sample(input logic signed [31:0] p, q, input logic r);
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    p_sample_i <= p;
    q_sample_i <= q;
    meter_reset_i <= r;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    meter_reset_i <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] g);
    @(posedge clk_i);
    go <= g;
    @(posedge clk_i);
    go <= 4'h0;
    idle(8);
  endtask
  task automatic tick(input logic [5:0] m);
    @(posedge clk_i);
    tick_go <= 1'b1;
    min_set <= m;
    @(posedge clk_i);
    tick_go <= 1'b0;
  endtask
  task automatic wait_rep;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (report_valid_o !== 1'b1 && n < 20);
    note(report_valid_o === 1'b1, "no report");
  endtask
  task automatic t_reset;
    chk_bus(`EMB_A_CTRL, 32'h10);
    chk_bus(`EMB_A_ASCALE, 32'h64);
    chk_bus(`EMB_A_RATIO, 32'h1);
    wb(1'b1, `EMB_A_NOM, 32'h1234);
    chk_bus(`EMB_A_NOM, 32'h0);
    wb(1'b1, 6'h0A, 32'hFF);
    chk_bus(6'h0A, 32'h0);
    chk_tot(active_demand_total_o, 64'h0);
  endtask
  // Ratio 3; pulses must be ignored while measuring
  task automatic t_meas;
    wb(1'b1, `EMB_A_RATIO, 32'h3);
    pulse(4'hF);
    sample(32'sh5, -32'sh2, 1'b0);
    sample(-32'sh4, 32'sh7, 1'b0);
    idle(4);
    chk_tot(active_demand_total_o, 64'hF);
    chk_tot(active_supply_total_o, 64'hC);
    chk_tot(reactive_demand_total_o, 64'h15);
    chk_tot(reactive_supply_total_o, 64'h6);
    sample(32'sh0, 32'sh0, 1'b1);
    idle(3);
    chk_tot(active_demand_total_o, 64'hF);
  endtask
  task automatic t_report;
    wb(1'b1, `EMB_A_CTRL, 32'h10C);
    idle(2);
    note(unit_mega_o === 1'b1, "prefix");
    tick(6'h07);
    idle(6);
    chk_bus(`EMB_A_STAT, 32'h0);
    tick(6'h0F);
    wait_rep;
    chk_tot(report_tot_o[0], 64'hF);
    chk_tot(report_tot_o[3], 64'h6);
    chk_tot(active_demand_total_o, 64'h0);
    chk_bus(`EMB_A_REP, 32'hF);
    chk_bus(`EMB_A_STAT, 32'h1);
  endtask
  task automatic t_cum;
    wb(1'b1, `EMB_A_CTRL, 32'h0E);
    sample(32'shA, 32'sh0, 1'b0);
    tick(6'h1E);
    wait_rep;
    chk_tot(report_tot_o[0], 64'h1E);
    chk_tot(active_demand_total_o, 64'h1E);
    sample(32'shA, 32'sh0, 1'b1);
    idle(2);
    chk_tot(active_demand_total_o, 64'h0);
  endtask
  task automatic t_imp;
    wb(1'b1, `EMB_A_CTRL, 32'h03);
    wb(1'b1, `EMB_A_ASCALE, 32'h0);
    chk_bus(`EMB_A_ASCALE, 32'h1);
    wb(1'b1, `EMB_A_RSCALE, 32'h4E20);
    chk_bus(`EMB_A_RSCALE, 32'h2710);
    wb(1'b1, `EMB_A_ASCALE, 32'h7);
    pulse(4'hD);
    pulse(4'h1);
    sample(32'sh9, 32'sh9, 1'b0);
    chk_tot(active_demand_total_o, 64'hE);
    chk_tot(active_supply_total_o, 64'h0);
    chk_tot(reactive_demand_total_o, 64'h2710);
    chk_tot(reactive_supply_total_o, 64'h2710);
    tick(6'h00);
    idle(6);
    chk_bus(`EMB_A_STAT, 32'h2);
    // Hourly interval: minute 45 is off the grid, minute 0 is on it
    wb(1'b1, `EMB_A_CTRL, 32'h17);
    tick(6'h2D);
    tick(6'h00);
    idle(6);
    chk_bus(`EMB_A_STAT, 32'h3);
  endtask
  task automatic t_nom;
    emb_tot_t m;
    wb(1'b1, `EMB_A_RATU, 32'hA);
    wb(1'b1, `EMB_A_RATI, 32'h14);
    for (int v = 0; v < 3; v++)
    begin
      m = fac[v] * 64'hC8;
      wb(1'b1, `EMB_A_CTRL, 32'h03 | (32'(v) << 9));
      idle(3);
      chk_bus(`EMB_A_NOM, 32'hC8);
      chk_bus(`EMB_A_MAXLO, m[31:0]);
      chk_bus(`EMB_A_MAXHI, m[63:32]);
    end
    // Unit nominal power keeps the ceiling small enough to reach
    wb(1'b1, `EMB_A_RATU, 32'h1);
    wb(1'b1, `EMB_A_RATI, 32'h1);
    wb(1'b1, `EMB_A_CTRL, 32'h02);
    idle(3);
    sample(32'sh7FFF_FFFF, 32'sh0, 1'b0);
    idle(2);
    chk_tot(active_demand_total_o, fac[0]);
    // Restart in mid-run clears a nonzero total and the settings
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(2);
    chk_tot(active_demand_total_o, 64'h0);
    chk_bus(`EMB_A_CTRL, 32'h10);
  endtask
  // Reset for ten cycles, then the scenarios in order
  initial
  begin
    idle(10);
    rst_i <= 1'b0;
    t_reset;
    t_meas;
    t_report;
    t_cum;
    t_imp;
    t_nom;
    test_done;
  end
endmodule

/* tb/emb_meter_chk.sv */
// Purpose: Concurrent checks on the metering block ports.
// Assumes: One clock; rst_i synchronous, active high.
// Notes: Bound onto every emb_meter instance.
module emb_meter_chk
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic sample_valid_i, // Sample strobe
  input wire logic active_demand_pulse_in_i, // Pin
  input wire logic active_supply_pulse_in_i, // Pin
  input wire logic reactive_demand_pulse_in_i, // Pin
  input wire logic reactive_supply_pulse_in_i, // Pin
  input wire logic meter_reset_i, // Total reset
  input wire logic [5:0] rtc_second_i, // Second
  input wire logic rtc_sec_tick_i, // Tick
  input wire emb_pkg::emb_tot_t active_demand_total_o, // Total
  input wire emb_pkg::emb_tot_t report_tot_o [4], // Snapshot
  input wire logic report_valid_o, // Report pulse
  input wire logic unit_mega_o // Prefix
);
  timeunit 1ns;
  timeprecision 1ps;
  import emb_pkg::*;
  logic any_pin;
  // Any pin high means a rising edge may be taken this cycle
  assign any_pin = active_demand_pulse_in_i | active_supply_pulse_in_i |
    reactive_demand_pulse_in_i | reactive_supply_pulse_in_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("data not idle");
  property p_rep_one; report_valid_o |=> !report_valid_o; endproperty
  a_rep_one: assert property (p_rep_one) else $error("long report");
  // Reports only follow an aligned tick two cycles earlier
  property p_rep_cause; report_valid_o |-> $past(rtc_sec_tick_i, 2) &&
    $past(rtc_second_i, 2) == 6'h00; endproperty
  a_rep_cause: assert property (p_rep_cause) else $error("stray report");
  property p_rep_snap;
    report_valid_o |-> report_tot_o[0] == $past(active_demand_total_o);
  endproperty
  a_rep_snap: assert property (p_rep_snap) else $error("bad snapshot");
  property p_rst_clear;
    $fell(rst_i) |-> active_demand_total_o == 64'h0 && !report_valid_o;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("not cleared");
  // Without a clear or report a total never falls
  property p_grow; !meter_reset_i ##1 !report_valid_o |->
    active_demand_total_o >= $past(active_demand_total_o); endproperty
  a_grow: assert property (p_grow) else $error("total fell");
  property p_quiet; !sample_valid_i && !any_pin && !meter_reset_i ##1
    !report_valid_o |-> $stable(active_demand_total_o); endproperty
  a_quiet: assert property (p_quiet) else $error("total moved");
  property p_mega; $changed(unit_mega_o) |-> wb_ack_o && $past(wb_we_i);
  endproperty
  a_mega: assert property (p_mega) else $error("prefix moved");
endmodule
bind emb_meter emb_meter_chk chk_u (.*);

/* tb/emb_meter_partner.sv */
// Purpose: Far side model: meter pulse pins and clock of day.
// Assumes: Requests are one cycle wide, set just after an edge.
// Notes: Pulses stay high four cycles, so a held level is seen.
module emb_meter_partner
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [3:0] go_i, // Start a pulse per pin
  input wire logic tick_go_i, // Issue a second tick
  input wire logic [5:0] min_i, // Minute for the tick
  output logic [3:0] pulse_o, // Meter pulse pins
  output logic [5:0] min_o, // Minute of hour
  output logic [5:0] sec_o, // Second of minute
  output logic tick_o // Second tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q [4] = '{default: 3'h0};
  logic tick_q = 1'b0;
  logic [5:0] min_q = 6'h00;
  logic [5:0] sec_q = 6'h1E;
  // Idle second is nonzero so only a commanded tick can align
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 4; i++)
      cnt_q[i] <= rst_i ? 3'h0 : go_i[i] ? 3'h4 :
        (cnt_q[i] != 3'h0) ? cnt_q[i] - 3'h1 : 3'h0;
    tick_q <= tick_go_i;
    sec_q <= tick_go_i ? 6'h00 : 6'h1E;
    if (tick_go_i)
      min_q <= min_i;
  end
  // A pin stays high while its counter runs
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pulse_o[i] = cnt_q[i] != 3'h0;
  end
  assign tick_o = tick_q;
  assign min_o = min_q;
  assign sec_o = sec_q;
endmodule
